// ===== uart_shadow_pkg.sv
`default_nettype none
package uart_shadow_pkg;
	// Register byte addresses; the sixteen data aliases span 0x30..0x6C
	localparam logic [31:0] SHADOW_BASE = 32'h5000_1030;
	localparam logic [31:0] SHADOW_LAST = 32'h5000_106C;
	localparam logic [31:0] SHADOW_DATA_10 = 32'h5000_1058;
	localparam logic [31:0] FIFO_CTRL_ADDR = 32'h5000_1008;
	localparam logic [31:0] LINE_STATUS_ADDR = 32'h5000_1014;
	localparam logic [31:0] MODE_ADDR = 32'h5000_1080;
	localparam logic [31:0] INT_STATUS_ADDR = 32'h5000_1084;
	localparam logic [31:0] INT_MASK_ADDR = 32'h5000_1088;
	// Field positions
	localparam int FCR_ENABLE = 0;
	localparam int FCR_RX_FLUSH = 1;
	localparam int FCR_TX_FLUSH = 2;
	localparam int LS_DATA_READY = 0;
	localparam int LS_OVERRUN = 1;
	localparam int LS_HOLD_EMPTY = 5;
	localparam int LS_TX_IDLE = 6;
	localparam int MODE_IR = 0;
	localparam int EV_RX = 0;
	localparam int EV_OVERRUN = 1;
	localparam int EV_HOLD_EMPTY = 2;
	localparam int EV_BITS = 3;
	// Reset values
	localparam logic RESET_FIFO_EN = 1'b0;
	localparam logic RESET_IR_MODE = 1'b0;
	localparam logic [2:0] RESET_INT_MASK = 3'h0;
	// Timing and sizes
	localparam int BIT_CYCLES_DEF = 16;
	localparam int FIFO_DEPTH_DEF = 16;
	// Serial line sequencer states
	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_start = 2'b01,
		st_data = 2'b10,
		st_stop = 2'b11
	} line_state_e;
endpackage : uart_shadow_pkg
`default_nettype wire

// ===== uart_byte_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module uart_byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk, // Core clock
	input wire logic nrst, // Async reset, active low
	input wire logic flush, // Empty the queue
	input wire logic push_valid, // Entry offered
	output logic push_ready, // Room for an entry
	input wire logic [WIDTH-1:0] push_data, // Entry to store
	output logic pop_valid, // Head entry present
	input wire logic pop_ready, // Head entry taken
	output logic [WIDTH-1:0] pop_data, // Head entry
	output logic [$clog2(DEPTH):0] level // Entries held
);
	localparam int AW = $clog2(DEPTH);

	// Refuse at elaboration any depth the pointer logic cannot wrap correctly
	if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_cfg
		$error("uart_byte_fifo: DEPTH must be a power of two >= 2");
	end

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0] wr;
		logic [AW:0] rd;
	} fifo_s;

	fifo_s s;
	fifo_s next_s;

	assign level = s.wr - s.rd;
	assign push_ready = (level != (AW+1)'(DEPTH));
	assign pop_valid = (s.wr != s.rd);
	assign pop_data = s.mem[s.rd[AW-1:0]];

	// A full queue refuses the push, so stored entries are never disturbed
	always_comb begin
		next_s = s;
		if (push_valid && push_ready) begin
			next_s.mem[s.wr[AW-1:0]] = push_data;
			next_s.wr = s.wr + 1'b1;
		end
		if (pop_valid && pop_ready)
			next_s.rd = s.rd + 1'b1;
		if (flush) begin
			next_s.wr = '0;
			next_s.rd = '0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			s <= '0;
		else
			s <= next_s;
	end
endmodule : uart_byte_fifo
`default_nettype wire

// ===== uart_shadow_data_port.sv
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module uart_shadow_data_port #(
	parameter int FIFO_DEPTH = uart_shadow_pkg::FIFO_DEPTH_DEF,
	parameter int BIT_CYCLES = uart_shadow_pkg::BIT_CYCLES_DEF
) (
	input wire logic core_clk, // Core clock, 10 MHz
	input wire logic nrst, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB write
	input wire logic [31:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	input wire logic sin, // Serial input
	input wire logic sir_in, // Infrared input, pulse high for a zero
	output logic sout, // Serial output
	output logic sir_out_n, // Infrared output, active low
	output logic irq // Level interrupt
);
	import uart_shadow_pkg::*;

	localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);
	localparam logic [15:0] BIT_HALF = 16'(BIT_CYCLES / 2 - 1);
	localparam logic [15:0] IR_PULSE = 16'((BIT_CYCLES * 3 / 16 < 1) ? 1 : BIT_CYCLES * 3 / 16);
	localparam int LW = $clog2(FIFO_DEPTH) + 1;

	// Refuse at elaboration what the 16-bit baud counter or the queues cannot serve
	if (BIT_CYCLES < 4 || BIT_CYCLES > 65535) begin : g_bad_bits
		$error("uart_shadow_data_port: BIT_CYCLES out of range");
	end
	if (FIFO_DEPTH < 2 || (1 << (LW - 1)) != FIFO_DEPTH) begin : g_bad_depth
		$error("uart_shadow_data_port: FIFO_DEPTH must be a power of two >= 2");
	end

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic fifo_en;
		logic ir_mode;
		logic [7:0] receive_buffer;
		logic rbr_valid;
		logic [7:0] transmit_holding;
		logic thr_full;
		logic overrun;
		logic tx_holding_empty_q;
		logic [EV_BITS-1:0] int_status;
		logic [EV_BITS-1:0] int_mask;
		logic irq;
		line_state_e tx_st;
		logic [15:0] tx_baud;
		logic [2:0] tx_bit;
		logic [7:0] tx_shift;
		logic sout;
		logic sir_out_n;
		line_state_e rx_st;
		logic [15:0] rx_baud;
		logic [2:0] rx_bit;
		logic [7:0] rx_shift;
	} port_s;

	port_s s;
	port_s next_s;

	logic acc, sh_hit, rd_sh, wr_sh, wr_fcr, fcr_chg, rx_flush, tx_flush;
	logic rx_line, rx_done, rxf_push, rxf_pop, rxf_ready, rxf_valid;
	logic txf_push, txf_pop, txf_ready, txf_valid, tx_load, src_valid;
	logic dr, tx_holding_empty, line_bit;
	logic [7:0] rxf_data, txf_data, rx_head, src_data;
	logic [LW-1:0] rxf_level, txf_level;
	logic [EV_BITS-1:0] ev;

	// Bus decode; an access completes on the edge that sees pready high
	assign acc = psel & penable & s.pready;
	assign sh_hit = (paddr >= SHADOW_BASE) && (paddr <= SHADOW_LAST) && (paddr[1:0] == 2'h0);
	assign rd_sh = acc & ~pwrite & sh_hit;
	assign wr_sh = acc & pwrite & sh_hit;
	assign wr_fcr = acc & pwrite & (paddr == FIFO_CTRL_ADDR);
	// Switching FIFO mode flushes both sides so no stale byte leaks across
	assign fcr_chg = pwdata[FCR_ENABLE] != s.fifo_en;
	assign rx_flush = wr_fcr & (pwdata[FCR_RX_FLUSH] | fcr_chg);
	assign tx_flush = wr_fcr & (pwdata[FCR_TX_FLUSH] | fcr_chg);

	// Receive path; infrared pulses are taken as already stretched to a bit
	assign rx_line = s.ir_mode ? ~sir_in : sin;
	assign rx_done = (s.rx_st == st_stop) && (s.rx_baud == BIT_LAST);
	assign rxf_push = rx_done & s.fifo_en;
	assign rxf_pop = rd_sh & s.fifo_en;
	assign rx_head = s.fifo_en ? rxf_data : s.receive_buffer;
	assign dr = s.fifo_en ? rxf_valid : s.rbr_valid;

	// Transmit source is the FIFO head or the single holding byte
	// full FIFO refuses the push
	assign txf_push = wr_sh & s.fifo_en;
	assign src_valid = s.fifo_en ? txf_valid : s.thr_full;
	assign src_data = s.fifo_en ? txf_data : s.transmit_holding;
	assign tx_load = (s.tx_st == st_idle) & src_valid;
	assign txf_pop = tx_load & s.fifo_en;
	assign tx_holding_empty = s.fifo_en ? ~txf_valid : ~s.thr_full;

	uart_byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) rx_fifo (
		.clk(core_clk),
		.nrst(nrst),
		.flush(rx_flush),
		.push_valid(rxf_push),
		.push_ready(rxf_ready),
		.push_data(s.rx_shift),
		.pop_valid(rxf_valid),
		.pop_ready(rxf_pop),
		.pop_data(rxf_data),
		.level(rxf_level)
	);

	uart_byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) tx_fifo (
		.clk(core_clk),
		.nrst(nrst),
		.flush(tx_flush),
		.push_valid(txf_push),
		.push_ready(txf_ready),
		.push_data(pwdata[7:0]),
		.pop_valid(txf_valid),
		.pop_ready(txf_pop),
		.pop_data(txf_data),
		.level(txf_level)
	);

	// Next-state logic for bus, flags, transmitter and receiver
	always_comb begin
		next_s = s;
		ev = '0;
		line_bit = 1'b1;
		// Answer every access after one wait state; data is held stable meanwhile
		next_s.pready = psel & penable & ~s.pready;
		next_s.pslverr = 1'b0;
		if (psel && penable && !s.pready) begin
			next_s.prdata = 32'h0000_0000;
			if (sh_hit) begin
				next_s.prdata[7:0] = rx_head;
			end else if (paddr == FIFO_CTRL_ADDR) begin
				next_s.prdata[FCR_ENABLE] = s.fifo_en;
			end else if (paddr == LINE_STATUS_ADDR) begin
				next_s.prdata[LS_DATA_READY] = dr;
				next_s.prdata[LS_OVERRUN] = s.overrun;
				next_s.prdata[LS_HOLD_EMPTY] = tx_holding_empty;
				next_s.prdata[LS_TX_IDLE] = tx_holding_empty & (s.tx_st == st_idle);
			end else if (paddr == MODE_ADDR) begin
				next_s.prdata[MODE_IR] = s.ir_mode;
			end else if (paddr == INT_STATUS_ADDR) begin
				next_s.prdata[EV_BITS-1:0] = s.int_status;
			end else if (paddr == INT_MASK_ADDR) begin
				next_s.prdata[EV_BITS-1:0] = s.int_mask;
			end else begin
				next_s.pslverr = 1'b1;
			end
		end

		// Configuration writes
		if (wr_fcr) begin
			next_s.fifo_en = pwdata[FCR_ENABLE];
			if (fcr_chg) begin
				next_s.rbr_valid = 1'b0;
				next_s.thr_full = 1'b0;
			end
		end
		if (acc && pwrite && paddr == MODE_ADDR)
			next_s.ir_mode = pwdata[MODE_IR];
		if (acc && pwrite && paddr == INT_MASK_ADDR)
			next_s.int_mask = pwdata[EV_BITS-1:0];

		// Single-byte receive buffer consumed by an alias read
		if (rd_sh && !s.fifo_en)
			next_s.rbr_valid = 1'b0;
		// Overrun is cleared by reading line status; a new overrun in that cycle wins
		if (acc && !pwrite && paddr == LINE_STATUS_ADDR)
			next_s.overrun = 1'b0;

		// Receiver: confirm start at mid-bit, then sample each bit centre
		next_s.rx_baud = s.rx_baud + 16'h0001;
		case (s.rx_st)
			st_idle: begin
				next_s.rx_baud = 16'h0000;
				if (!rx_line)
					next_s.rx_st = st_start;
			end
			st_start: begin
				if (s.rx_baud == BIT_HALF) begin
					next_s.rx_baud = 16'h0000;
					next_s.rx_bit = 3'h0;
					next_s.rx_st = rx_line ? st_idle : st_data;
				end
			end
			st_data: begin
				if (s.rx_baud == BIT_LAST) begin
					next_s.rx_baud = 16'h0000;
					next_s.rx_shift = {rx_line, s.rx_shift[7:1]};
					next_s.rx_bit = s.rx_bit + 3'h1;
					if (s.rx_bit == 3'h7)
						next_s.rx_st = st_stop;
				end
			end
			st_stop: begin
				if (rx_done)
					next_s.rx_st = st_idle;
			end
			default: next_s.rx_st = st_idle;
		endcase
		if (rx_done) begin
			ev[EV_RX] = 1'b1;
			if (s.fifo_en) begin
				if (!rxf_ready) begin
					next_s.overrun = 1'b1;
					ev[EV_OVERRUN] = 1'b1;
				end
			end else begin
				if (s.rbr_valid && !rd_sh) begin
					next_s.overrun = 1'b1;
					ev[EV_OVERRUN] = 1'b1;
				end
				next_s.receive_buffer = s.rx_shift;
				next_s.rbr_valid = 1'b1;
			end
		end

		// Transmitter: idle, start bit, eight data bits LSB first, stop bit
		next_s.tx_baud = s.tx_baud + 16'h0001;
		case (s.tx_st)
			st_idle: begin
				next_s.tx_baud = 16'h0000;
				if (tx_load) begin
					next_s.tx_shift = src_data;
					next_s.tx_st = st_start;
					if (!s.fifo_en)
						next_s.thr_full = 1'b0;
				end
			end
			st_start: begin
				if (s.tx_baud == BIT_LAST) begin
					next_s.tx_baud = 16'h0000;
					next_s.tx_bit = 3'h0;
					next_s.tx_st = st_data;
				end
			end
			st_data: begin
				if (s.tx_baud == BIT_LAST) begin
					next_s.tx_baud = 16'h0000;
					next_s.tx_shift = {1'b0, s.tx_shift[7:1]};
					next_s.tx_bit = s.tx_bit + 3'h1;
					if (s.tx_bit == 3'h7)
						next_s.tx_st = st_stop;
				end
			end
			st_stop: begin
				if (s.tx_baud == BIT_LAST)
					next_s.tx_st = st_idle;
			end
			default: next_s.tx_st = st_idle;
		endcase
		if (wr_sh && !s.fifo_en) begin
			next_s.transmit_holding = pwdata[7:0];
			next_s.thr_full = 1'b1;
		end

		case (next_s.tx_st)
			st_start: line_bit = 1'b0;
			st_data: line_bit = next_s.tx_shift[0];
			default: line_bit = 1'b1;
		endcase
		next_s.sout = next_s.ir_mode | line_bit;
		// Infrared sends a short low pulse, 3/16 of a bit, for each zero
		next_s.sir_out_n = ~(next_s.ir_mode & ~line_bit & (next_s.tx_baud < IR_PULSE));

		// Sticky events, write one to clear; a new event in the same cycle wins
		next_s.tx_holding_empty_q = tx_holding_empty;
		ev[EV_HOLD_EMPTY] = tx_holding_empty & ~s.tx_holding_empty_q;
		if (acc && pwrite && paddr == INT_STATUS_ADDR)
			next_s.int_status = s.int_status & ~pwdata[EV_BITS-1:0];
		next_s.int_status = next_s.int_status | ev;
		next_s.irq = |(next_s.int_status & next_s.int_mask);
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			s <= '0;
			s.fifo_en <= RESET_FIFO_EN;
			s.ir_mode <= RESET_IR_MODE;
			s.int_mask <= RESET_INT_MASK;
			s.tx_holding_empty_q <= 1'b1;
			s.sout <= 1'b1;
			s.sir_out_n <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from the state register
	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign sout = s.sout;
	assign sir_out_n = s.sir_out_n;
	assign irq = s.irq;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	sequence alias_setup_s;
		psel && !penable && sh_hit;
	endsequence
	sequence alias_access_s;
		psel && penable && !s.pready && sh_hit;
	endsequence
	sequence tx_load_s;
		tx_load && !next_s.ir_mode;
	endsequence

	alias_no_error_a: assert property (alias_setup_s ##1 alias_access_s |=> pready && !pslverr)
		else $error("alias access answered with error");
	read_byte_a: assert property (alias_access_s and !pwrite |=> prdata == {24'h0, $past(rx_head)})
		else $error("alias read returned wrong byte");
	read_head_a: assert property (alias_access_s and !pwrite && s.fifo_en && rxf_valid |=> prdata[7:0] == $past(rxf_data))
		else $error("fifo read not from head");
	read_pop_a: assert property (rxf_pop && rxf_valid && !rxf_push && !rx_flush |=> rxf_level == $past(rxf_level) - 1)
		else $error("alias read did not pop receive fifo");
	overrun_keep_a: assert property (rxf_push && !rxf_ready && !rxf_pop && !rx_flush |=> s.overrun && rxf_level == $past(rxf_level))
		else $error("full receive fifo changed or no overrun");
	overrun_over_a: assert property (rx_done && !s.fifo_en && s.rbr_valid && !rd_sh && !wr_fcr |=> s.overrun && s.receive_buffer == $past(s.rx_shift))
		else $error("unread byte not overwritten with overrun");
	tx_holding_empty_clear_a: assert property (wr_sh && !s.fifo_en && tx_holding_empty && !wr_fcr |=> !tx_holding_empty)
		else $error("holding empty still set after write");
	thr_replace_a: assert property (wr_sh && !s.fifo_en && s.thr_full && !tx_load |=> s.transmit_holding == $past(pwdata[7:0]) && s.thr_full)
		else $error("pending byte not replaced");
	tx_accept_a: assert property (txf_push && txf_level < LW'(FIFO_DEPTH) && !txf_pop && !tx_flush |=> txf_level == $past(txf_level) + 1)
		else $error("write not queued below depth");
	tx_drop_a: assert property (txf_push && txf_level == LW'(FIFO_DEPTH) && !txf_pop && !tx_flush |=> txf_level == $past(txf_level) && txf_data == $past(txf_data))
		else $error("write to full fifo not dropped");
	start_bit_a: assert property (tx_load_s |=> s.tx_st == st_start && !sout [*2])
		else $error("start bit not driven low");
endmodule : uart_shadow_data_port
`default_nettype wire

// ===== uart_line_partner.sv
`timescale 1ns/1ps
`default_nettype none
// Remote serial end: sends 8N1 frames on sin and decodes frames seen on sout
module uart_line_partner #(
	parameter int BIT_CYCLES = 16
) (
	input wire logic core_clk, // Core clock
	input wire logic sout, // Line from the block
	output logic sin // Line into the block
);
	logic [7:0] rx_q[$];
	logic [7:0] rb;
	initial sin = 1'b1;
	task automatic send_byte(input logic [7:0] b);
		for (int i = 0; i < 10; i++) begin
			sin <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
			repeat (BIT_CYCLES) @(posedge core_clk);
		end
	endtask : send_byte
	// decode serial output
	// Sampling at mid-bit leaves half a bit of slack for the block's edge timing
	always begin
		@(posedge core_clk);
		if (sout === 1'b0) begin
			repeat (BIT_CYCLES / 2) @(posedge core_clk);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CYCLES) @(posedge core_clk);
				rb[i] = sout;
			end
			repeat (BIT_CYCLES) @(posedge core_clk);
			rx_q.push_back(rb);
		end
	end
endmodule : uart_line_partner
`default_nettype wire

// ===== uart_shadow_data_port_test.sv
`timescale 1ns/1ps
`default_nettype none
module uart_shadow_data_port_test;
	import uart_shadow_pkg::*;
	localparam int BC = 16;
	localparam int FD = 4;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, sin, sout, sir_out_n, irq, err;
	logic sir_in = 1'b0;
	int n_mismatch = 0;
	int checks = 0;
	// Clock, 100 ns period
	always #50 core_clk = ~core_clk;
	// Infrared input idles low; the infrared test drives one frame on it
	uart_shadow_data_port #(.FIFO_DEPTH(FD), .BIT_CYCLES(BC)) i_uart_shadow_data_port (.core_clk(core_clk),
		.nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sin(sin), .sir_in(sir_in), .sout(sout),
		.sir_out_n(sir_out_n), .irq(irq));
	uart_line_partner #(.BIT_CYCLES(BC)) i_uart_line_partner (.core_clk(core_clk), .sout(sout), .sin(sin));
	task automatic complete_run;
		$display("Counts: %0d checks, %0d mismatches", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : complete_run
	task automatic cmp_word(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp_word
	task automatic cmp_bit(input string nm, input logic e, input logic g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("FAIL %s expected %b seen %b", nm, e, g);
		end
	endtask : cmp_bit
	// One APB transfer; the request holds until pready is seen high
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge core_clk);
			if (pready === 1'b1) break;
		end
		if (n == 20) begin
			n_mismatch++;
			complete_run();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wait_rx(input int k);
		int n;
		for (n = 0; n < 20 * BC * k && i_uart_line_partner.rx_q.size() < k; n++) @(posedge core_clk);
		if (i_uart_line_partner.rx_q.size() < k) begin
			n_mismatch++;
			complete_run();
		end
	endtask : wait_rx
	task automatic t_reset;
		apb(1'b0, LINE_STATUS_ADDR, 32'h0);
		cmp_word("line status", 32'h60, rd);
		apb(1'b0, INT_MASK_ADDR, 32'h0);
		cmp_word("int mask", 32'h0, rd);
		// Word just past the last alias must not decode
		apb(1'b0, SHADOW_LAST + 32'h4, 32'h0);
		cmp_bit("unmapped err", 1'b1, err);
		cmp_word("unmapped data", 32'h0, rd);
		$display("Test reset finished");
	endtask : t_reset
	task automatic t_rx;
		logic [31:0] al[3] = '{SHADOW_DATA_10, SHADOW_BASE, SHADOW_LAST};
		logic [7:0] bs[3] = '{8'hA5, 8'h3C, 8'h81};
		for (int i = 0; i < 3; i++) begin
			i_uart_line_partner.send_byte(bs[i]);
			repeat (2) @(posedge core_clk);
			apb(1'b0, LINE_STATUS_ADDR, 32'h0);
			cmp_bit("data ready", 1'b1, rd[LS_DATA_READY]);
			apb(1'b0, al[i], 32'h0);
			cmp_word("rx byte", {24'h0, bs[i]}, rd);
		end
		$display("Test rx finished");
	endtask : t_rx
	task automatic t_ovr;
		i_uart_line_partner.send_byte(8'h11);
		i_uart_line_partner.send_byte(8'h22);
		repeat (2) @(posedge core_clk);
		apb(1'b0, LINE_STATUS_ADDR, 32'h0);
		cmp_bit("overrun", 1'b1, rd[LS_OVERRUN]);
		apb(1'b0, SHADOW_DATA_10, 32'h0);
		cmp_word("newest byte", 32'h22, rd);
		$display("Test overrun finished");
	endtask : t_ovr
	task automatic t_rx_fifo;
		apb(1'b1, FIFO_CTRL_ADDR, 32'h1);
		// One byte more than the queue holds
		for (int i = 0; i <= FD; i++) i_uart_line_partner.send_byte(8'h40 + 8'(i));
		repeat (2) @(posedge core_clk);
		apb(1'b0, LINE_STATUS_ADDR, 32'h0);
		cmp_bit("fifo overrun", 1'b1, rd[LS_OVERRUN]);
		for (int i = 0; i < FD; i++) begin
			apb(1'b0, SHADOW_BASE + 32'(4 * i), 32'h0);
			cmp_word("fifo head", 32'h40 + 32'(i), rd);
		end
		apb(1'b0, LINE_STATUS_ADDR, 32'h0);
		cmp_bit("fifo drained", 1'b0, rd[LS_DATA_READY]);
		// Receive flush with the enable kept must empty the queue
		i_uart_line_partner.send_byte(8'h5A);
		repeat (2) @(posedge core_clk);
		apb(1'b1, FIFO_CTRL_ADDR, 32'h3);
		apb(1'b0, LINE_STATUS_ADDR, 32'h0);
		cmp_bit("rx flushed", 1'b0, rd[LS_DATA_READY]);
		apb(1'b1, FIFO_CTRL_ADDR, 32'h0);
		$display("Test rx fifo finished");
	endtask : t_rx_fifo
	task automatic t_tx;
		i_uart_line_partner.rx_q.delete();
		apb(1'b0, LINE_STATUS_ADDR, 32'h0);
		cmp_bit("hold empty", 1'b1, rd[LS_HOLD_EMPTY]);
		apb(1'b1, SHADOW_DATA_10, 32'hA1);
		apb(1'b1, SHADOW_DATA_10, 32'hB2);
		apb(1'b0, LINE_STATUS_ADDR, 32'h0);
		cmp_bit("hold full", 1'b0, rd[LS_HOLD_EMPTY]);
		apb(1'b1, SHADOW_BASE, 32'hC3);
		wait_rx(2);
		cmp_word("first out", 32'hA1, 32'(i_uart_line_partner.rx_q[0]));
		cmp_word("replaced out", 32'hC3, 32'(i_uart_line_partner.rx_q[1]));
		$display("Test tx finished");
	endtask : t_tx
	task automatic t_tx_fifo;
		i_uart_line_partner.rx_q.delete();
		apb(1'b1, FIFO_CTRL_ADDR, 32'h1);
		// One goes straight to the shifter, FD queue, the rest must be lost
		for (int i = 0; i < FD + 3; i++) apb(1'b1, SHADOW_DATA_10, 32'h50 + 32'(i));
		wait_rx(FD + 1);
		repeat (12 * BC) @(posedge core_clk);
		cmp_word("bytes sent", 32'(FD + 1), 32'(i_uart_line_partner.rx_q.size()));
		for (int i = 0; i <= FD; i++) begin
			cmp_word("fifo out", 32'h50 + 32'(i), 32'(i_uart_line_partner.rx_q[i]));
		end
		apb(1'b1, FIFO_CTRL_ADDR, 32'h0);
		$display("Test tx fifo finished");
	endtask : t_tx_fifo
	task automatic t_irq;
		apb(1'b1, INT_STATUS_ADDR, 32'h7);
		apb(1'b1, INT_MASK_ADDR, 32'h1 << EV_RX);
		i_uart_line_partner.send_byte(8'h77);
		repeat (3) @(posedge core_clk);
		cmp_bit("irq raised", 1'b1, irq);
		apb(1'b0, SHADOW_DATA_10, 32'h0);
		apb(1'b1, INT_STATUS_ADDR, 32'h1 << EV_RX);
		repeat (2) @(posedge core_clk);
		cmp_bit("irq cleared", 1'b0, irq);
		apb(1'b1, INT_MASK_ADDR, 32'h0);
		i_uart_line_partner.send_byte(8'h78);
		repeat (3) @(posedge core_clk);
		cmp_bit("irq masked", 1'b0, irq);
		apb(1'b0, INT_STATUS_ADDR, 32'h0);
		cmp_bit("rx event", 1'b1, rd[EV_RX]);
		apb(1'b0, SHADOW_DATA_10, 32'h0);
		cmp_word("rx byte", 32'h78, rd);
		$display("Test irq finished");
	endtask : t_irq
	task automatic t_ir;
		int n;
		logic pv, hi;
		logic [7:0] ib;
		ib = 8'h6B;
		n = 0;
		pv = 1'b1;
		hi = 1'b1;
		apb(1'b1, MODE_ADDR, 32'h1 << MODE_IR);
		apb(1'b1, SHADOW_DATA_10, 32'h0F);
		// Start bit plus four zero data bits give five pulses
		repeat (12 * BC) begin
			@(posedge core_clk);
			if (pv === 1'b1 && sir_out_n === 1'b0) n++;
			pv = sir_out_n;
			hi = hi & sout;
		end
		cmp_word("ir pulses", 32'd5, 32'(n));
		cmp_bit("sout idle", 1'b1, hi);
		// Infrared frame in: input high for each zero bit, held the whole bit
		for (int i = 0; i < 10; i++) begin
			sir_in <= (i == 0) ? 1'b1 : (i == 9) ? 1'b0 : ~ib[i-1];
			repeat (BC) @(posedge core_clk);
		end
		repeat (2) @(posedge core_clk);
		apb(1'b0, SHADOW_BASE, 32'h0);
		cmp_word("ir rx byte", 32'h6B, rd);
		apb(1'b1, MODE_ADDR, 32'h0);
		$display("Test infrared finished");
	endtask : t_ir
	// Main sequence
	initial begin
		repeat (3) @(posedge core_clk);
		nrst <= 1'b1;
		t_reset();
		t_rx();
		t_ovr();
		t_rx_fifo();
		t_tx();
		t_tx_fifo();
		t_irq();
		t_ir();
		complete_run();
	end
endmodule : uart_shadow_data_port_test
`default_nettype wire
